/* design/eeprom_link_if.sv */
// Purpose: Two-wire link between the bus master and the EEPROM slave.
// Assumes: Serial clock is driven only by the master.
// Notes:   Data line is open drain with a pull-up; resolved here.
`timescale 1ns/1ns
`default_nettype none
interface eeprom_link_if;
  logic scl;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_sda_out;
  logic s_sda_oe;
  logic sda_line;

  // Pull-up wins unless an enabled driver pulls low
  assign sda_line = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

  modport master (output scl, output m_sda_out, output m_sda_oe, input sda_line);
  modport slave  (input scl, input sda_line, output s_sda_out, output s_sda_oe);
endinterface
`default_nettype wire

/* design/eeprom_master.sv */
// Purpose: Two-wire bus master issuing single-byte writes and random reads.
// Assumes: Serial clock made here from the system clock by a divider.
// Notes:   Read bytes queue in a small FIFO; a full FIFO stalls the master.
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_state_type;

  fifo_state_type f_reg;
  fifo_state_type f_next;
  logic [WIDTH-1:0] store [DEPTH];
  logic             full;
  logic             empty;

  assign empty     = (f_reg.wp == f_reg.rp);
  assign full      = (f_reg.wp[AW] != f_reg.rp[AW]) && (f_reg.wp[AW-1:0] == f_reg.rp[AW-1:0]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = store[f_reg.rp[AW-1:0]];

  always_comb begin
    f_next = f_reg;
    if (in_valid && !full) begin
      f_next.wp = f_reg.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      f_next.rp = f_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      store[f_reg.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

module eeprom_master (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Two-wire link
  eeprom_link_if.master    link,
  // Command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_read,
  input  wire logic [12:0] cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic [2:0]  target_select,
  // Read data
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [7:0]       rd_data,
  // Status
  output logic             busy,
  output logic             nack_error
);
  typedef enum logic [5:0] {
    H_IDLE  = 6'h01,
    H_START = 6'h02,
    H_TX    = 6'h04,
    H_RX    = 6'h08,
    H_STOP  = 6'h10,
    H_PUSH  = 6'h20
  } hstate_type;

  typedef struct packed {
    logic        sda_m;
    logic        sda_s;
    hstate_type  state;
    logic [4:0]  tcnt;
    logic [1:0]  phase;
    logic [3:0]  slot;
    logic [2:0]  step;
    logic        rd;
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  sel;
    logic [7:0]  shreg;
    logic [7:0]  rdata;
    logic        scl;
    logic        sda_oe;
    logic        nack;
    logic        err;
  } host_state_type;

  host_state_type h_reg;
  host_state_type h_next;
  logic           tick;
  logic           push_ready;

  // Byte sent at each step of a transaction
  function automatic logic [7:0] step_byte(input logic [2:0] step, input host_state_type h);
    unique case (step)
      3'h0:    step_byte = {eeprom_pkg::DEV_TYPE, h.sel, eeprom_pkg::DIR_WRITE};
      3'h1:    step_byte = {3'h0, h.addr[12:8]};
      3'h2:    step_byte = h.addr[7:0];
      3'h3:    step_byte = h.wdata;
      default: step_byte = {eeprom_pkg::DEV_TYPE, h.sel, eeprom_pkg::DIR_READ};
    endcase
  endfunction

  assign tick      = (h_reg.tcnt == 5'(eeprom_pkg::SCL_QUARTER_CYCLES - 1));
  assign cmd_ready = (h_reg.state == H_IDLE);

  always_comb begin
    h_next       = h_reg;
    h_next.sda_m = link.sda_line;
    h_next.sda_s = h_reg.sda_m;
    h_next.tcnt  = tick ? 5'h00 : h_reg.tcnt + 5'h01;
    if (h_reg.state == H_IDLE) begin
      h_next.tcnt = 5'h00;
      if (cmd_valid) begin
        h_next.rd    = cmd_read;
        h_next.addr  = cmd_addr;
        h_next.wdata = cmd_wdata;
        h_next.sel   = target_select;
        h_next.step  = 3'h0;
        h_next.phase = 2'h0;
        h_next.err   = 1'b0;
        h_next.state = H_START;
      end
    end else if (h_reg.state == H_PUSH) begin
      if (push_ready) begin
        h_next.state = H_IDLE;
      end
    end else if (tick) begin
      h_next.phase = h_reg.phase + 2'h1;
      unique case (h_reg.state)
        H_START: begin
          unique case (h_reg.phase)
            2'h0: h_next.sda_oe = 1'b0;
            2'h1: h_next.scl    = 1'b1;
            2'h2: h_next.sda_oe = 1'b1;
            2'h3: begin
              h_next.scl   = 1'b0;
              h_next.slot  = 4'h0;
              h_next.shreg = step_byte(h_reg.step, h_reg);
              h_next.state = H_TX;
            end
          endcase
        end
        H_TX: begin
          unique case (h_reg.phase)
            2'h0: h_next.sda_oe = (h_reg.slot != 4'h8) && !h_reg.shreg[7];
            2'h1: h_next.scl    = 1'b1;
            2'h2: h_next.nack   = h_reg.sda_s;
            2'h3: begin
              h_next.scl  = 1'b0;
              h_next.slot = h_reg.slot + 4'h1;
              if (h_reg.slot != 4'h8) begin
                h_next.shreg = {h_reg.shreg[6:0], 1'b0};
              end else if (h_reg.nack) begin
                // Busy device: repeated start and address again
                h_next.state = (h_reg.step == 3'h0) ? H_START : H_STOP;
                h_next.err   = (h_reg.step != 3'h0);
                h_next.rd    = h_reg.rd && (h_reg.step == 3'h0);
              end else if (h_reg.step == 3'h4) begin
                h_next.slot  = 4'h0;
                h_next.state = H_RX;
              end else if (h_reg.step == 3'h3 || (h_reg.step == 3'h2 && h_reg.rd)) begin
                // Dummy write ends in a repeated start
                h_next.state = (h_reg.step == 3'h3) ? H_STOP : H_START;
                h_next.step  = 3'h4;
              end else begin
                // Word address follows the poll at once
                h_next.slot  = 4'h0;
                h_next.step  = h_reg.step + 3'h1;
                h_next.shreg = step_byte(h_reg.step + 3'h1, h_reg);
              end
            end
          endcase
        end
        H_RX: begin
          unique case (h_reg.phase)
            // Line left released on the ninth clock
            2'h0: h_next.sda_oe = 1'b0;
            2'h1: h_next.scl    = 1'b1;
            2'h2: begin
              if (h_reg.slot != 4'h8) begin
                h_next.shreg = {h_reg.shreg[6:0], h_reg.sda_s};
              end
            end
            2'h3: begin
              h_next.scl  = 1'b0;
              h_next.slot = h_reg.slot + 4'h1;
              if (h_reg.slot == 4'h8) begin
                h_next.rdata = h_reg.shreg;
                h_next.state = H_STOP;
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (h_reg.phase)
            2'h0: h_next.sda_oe = 1'b1;
            2'h1: h_next.scl    = 1'b1;
            2'h2: h_next.sda_oe = 1'b0;
            2'h3: h_next.state  = h_reg.rd ? H_PUSH : H_IDLE;
          endcase
        end
        default: h_next.state = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      h_reg       <= '0;
      h_reg.sda_m <= 1'b1;
      h_reg.sda_s <= 1'b1;
      h_reg.scl   <= 1'b1;
      h_reg.state <= H_IDLE;
    end else begin
      h_reg <= h_next;
    end
  end

  // A full buffer holds the master in the push state
  byte_fifo #(
    .WIDTH (eeprom_pkg::BYTE_W),
    .DEPTH (eeprom_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (h_reg.state == H_PUSH),
    .in_ready  (push_ready),
    .in_data   (h_reg.rdata),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign link.scl       = h_reg.scl;
  assign link.m_sda_out = 1'b0;
  assign link.m_sda_oe  = h_reg.sda_oe;
  assign busy           = (h_reg.state != H_IDLE);
  assign nack_error     = h_reg.err;
endmodule
`default_nettype wire

/* design/eeprom_pkg.sv */
// Purpose: Shared constants for the two-wire EEPROM slave and its bus master.
// Assumes: 10 MHz system clock; the larger (8192 x 8) array organisation.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`default_nettype none
package eeprom_pkg;

  // Array organisation
  localparam int         ADDR_W       = 13;
  localparam int         MEM_DEPTH    = 8192;
  localparam int         PAGE_W       = 5;
  localparam int         PAGE_BYTES   = 32;
  localparam int         BYTE_W       = 8;

  // Slave address: fixed device-type nibble, then select bits, then direction
  localparam logic [3:0] DEV_TYPE     = 4'ha;
  localparam logic       DIR_READ     = 1'h1;
  localparam logic       DIR_WRITE    = 1'h0;

  // Write-protected upper quarter: top two address bits both set
  localparam logic [1:0] PROTECT_TOP  = 2'h3;

  // Timing: clock period, maximum programming time, serial clock period
  localparam int         CLK_PERIOD_NS      = 32'h0000_0064;
  localparam int         PROG_TIME_NS       = 32'h0098_9680;
  localparam int         PROG_CYCLES        = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int         SCL_PERIOD_NS      = 32'h0000_2710;
  localparam int         SCL_QUARTER_CYCLES = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;

  // Read-data buffer in the master
  localparam int         FIFO_DEPTH   = 4;

endpackage
`default_nettype wire

/* design/eeprom_slave.sv */
// Purpose: Two-wire serial EEPROM slave: byte/page write, polling, reads.
// Assumes: Link pins arrive asynchronously and are double-registered.
// Notes:   Two-byte word address; bits above the array are dropped.
//
// What this block does
// - Write: address byte, word address, data acked
// - Stop after write starts programming cycle
// - Ignore all bus traffic while programming
// - Page write: up to 32 bytes acked
// - Write increments only low five pointer bits
// - Low five bits wrap inside the page
// - Extra page bytes overwrite earliest positions
// - No address acknowledge while busy
// - Master polls with write address until ack
// - After poll: address at once, or stop
// - Direction bit one selects the read forms
// - Master ends read with no-ack, stop
// - Counter holds last accessed location plus one
// - Read address acked, byte at counter shifted
// - Random read: dummy write, repeated start, read
// - Master ack requests the next sequential byte
// - Read counter wraps over whole array
// - Address: type nibble, select bits, direction
// - Protect input high blocks upper-quarter programming
// - No ack after byte: release, await stop
`timescale 1ns/1ns
`default_nettype none
module eeprom_slave #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Two-wire link
  eeprom_link_if.slave    link,
  // Straps
  input  wire logic [2:0] device_select_pins,
  input  wire logic       write_protect_input,
  // Status
  output logic            busy
);

  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_RECV = 6'h02,
    D_ACK  = 6'h04,
    D_SEND = 6'h08,
    D_MACK = 6'h10,
    D_PROG = 6'h20
  } dstate_type;

  typedef enum logic [3:0] {
    ROLE_DEV  = 4'h1,
    ROLE_AHI  = 4'h2,
    ROLE_ALO  = 4'h4,
    ROLE_DATA = 4'h8
  } role_type;

  typedef struct packed {
    logic                           scl_m;
    logic                           scl_s;
    logic                           scl_d;
    logic                           sda_m;
    logic                           sda_s;
    logic                           sda_d;
    logic                           wp_m;
    logic                           wp_s;
    logic [2:0]                     sel_m;
    logic [2:0]                     sel_s;
    dstate_type                     state;
    role_type                       role;
    logic [3:0]                     bitcnt;
    logic [7:0]                     shift;
    logic [7:0]                     tx;
    logic [eeprom_pkg::ADDR_W-1:0]  ptr;
    logic [4:0]                     ahi;
    logic                           send_after;
    logic                           sda_oe;
    logic [31:0]                    pmask;
    logic [31:0]                    pcnt;
    logic [5:0]                     pidx;
    logic                           busy;
  } dev_state_type;

  dev_state_type s_reg;
  dev_state_type s_next;

  logic [7:0]                    mem  [eeprom_pkg::MEM_DEPTH];
  logic [7:0]                    pbuf [eeprom_pkg::PAGE_BYTES];
  logic                          mem_we;
  logic [eeprom_pkg::ADDR_W-1:0] mem_wa;
  logic [7:0]                    mem_wd;
  logic                          pbuf_we;
  logic [4:0]                    pbuf_wa;
  logic [7:0]                    pbuf_wd;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic load_byte;
  logic [7:0] rd_byte;

  assign scl_rise = s_reg.scl_s & ~s_reg.scl_d;
  assign scl_fall = ~s_reg.scl_s & s_reg.scl_d;
  assign start_c  = s_reg.scl_s & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s;
  assign stop_c   = s_reg.scl_s & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s;
  assign rd_byte  = mem[s_reg.ptr];

  always_comb begin
    s_next    = s_reg;
    mem_we    = 1'b0;
    mem_wa    = '0;
    mem_wd    = '0;
    pbuf_we   = 1'b0;
    pbuf_wa   = '0;
    pbuf_wd   = '0;
    load_byte = 1'b0;

    // Pins pass two flops before any logic reads them
    s_next.scl_m = link.scl;
    s_next.scl_s = s_reg.scl_m;
    s_next.scl_d = s_reg.scl_s;
    s_next.sda_m = link.sda_line;
    s_next.sda_s = s_reg.sda_m;
    s_next.sda_d = s_reg.sda_s;
    s_next.wp_m  = write_protect_input;
    s_next.wp_s  = s_reg.wp_m;
    s_next.sel_m = device_select_pins;
    s_next.sel_s = s_reg.sel_m;

    if (s_reg.state == D_PROG) begin
      // Inputs ignored while busy
      // Page buffer drains one byte per cycle; the cycle count dwarfs 32
      if (!s_reg.pidx[5]) begin
        mem_we      = s_reg.pmask[s_reg.pidx[4:0]];
        mem_wa      = {s_reg.ptr[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], s_reg.pidx[4:0]};
        mem_wd      = pbuf[s_reg.pidx[4:0]];
        s_next.pidx = s_reg.pidx + 6'h01;
      end
      if (s_reg.pcnt == 32'h0000_0000) begin
        s_next.state = D_IDLE;
        s_next.busy  = 1'b0;
        s_next.pmask = '0;
      end else begin
        s_next.pcnt = s_reg.pcnt - 32'h0000_0001;
      end
    end else if (start_c) begin
      s_next.state  = D_RECV;
      s_next.role   = ROLE_DEV;
      s_next.bitcnt = '0;
      s_next.sda_oe = 1'b0;
      s_next.pmask  = '0;
    end else if (stop_c) begin
      s_next.sda_oe = 1'b0;
      s_next.state  = D_IDLE;
      if (s_reg.role == ROLE_DATA && s_reg.pmask != '0 &&
          !(s_reg.wp_s && s_reg.ptr[eeprom_pkg::ADDR_W-1 -: 2] == eeprom_pkg::PROTECT_TOP)) begin
        s_next.state = D_PROG;
        s_next.pcnt  = 32'(PROG_CYCLES - 1);
        s_next.pidx  = '0;
        s_next.busy  = 1'b1;
      end else begin
        s_next.pmask = '0;
      end
    end else begin
      unique case (s_reg.state)
        D_IDLE: begin
        end
        D_PROG: begin
        end
        D_RECV: begin
          if (scl_rise && s_reg.bitcnt != 4'h8) begin
            s_next.shift  = {s_reg.shift[6:0], s_reg.sda_s};
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end else if (scl_fall && s_reg.bitcnt == 4'h8) begin
            s_next.bitcnt     = '0;
            s_next.send_after = 1'b0;
            s_next.sda_oe     = 1'b1;
            s_next.state      = D_ACK;
            unique case (s_reg.role)
              ROLE_DEV: begin
                // Type nibble and select bits must match
                if (s_reg.shift[7:1] == {eeprom_pkg::DEV_TYPE, s_reg.sel_s}) begin
                  s_next.send_after = (s_reg.shift[0] == eeprom_pkg::DIR_READ);
                  s_next.role       = (s_reg.shift[0] == eeprom_pkg::DIR_READ) ? ROLE_DEV : ROLE_AHI;
                end else begin
                  s_next.sda_oe = 1'b0;
                  s_next.state  = D_IDLE;
                end
              end
              ROLE_AHI: begin
                s_next.ahi  = s_reg.shift[4:0];
                s_next.role = ROLE_ALO;
              end
              ROLE_ALO: begin
                s_next.ptr   = {s_reg.ahi, s_reg.shift};
                s_next.role  = ROLE_DATA;
                s_next.pmask = '0;
              end
              ROLE_DATA: begin
                pbuf_we                    = 1'b1;
                pbuf_wa                    = s_reg.ptr[4:0];
                pbuf_wd                    = s_reg.shift;
                s_next.pmask[s_reg.ptr[4:0]] = 1'b1;
                s_next.ptr[4:0]            = s_reg.ptr[4:0] + 5'h01;
              end
              default: begin
                s_next.sda_oe = 1'b0;
                s_next.state  = D_IDLE;
              end
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            if (s_reg.send_after) begin
              load_byte = 1'b1;
            end else begin
              s_next.sda_oe = 1'b0;
              s_next.state  = D_RECV;
            end
          end
        end
        D_SEND: begin
          if (scl_fall) begin
            if (s_reg.bitcnt == 4'h8) begin
              s_next.sda_oe = 1'b0;
              s_next.bitcnt = '0;
              s_next.state  = D_MACK;
            end else begin
              s_next.tx     = {s_reg.tx[6:0], 1'b0};
              s_next.sda_oe = ~s_reg.tx[6];
              s_next.bitcnt = s_reg.bitcnt + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            // No acknowledge: stop sending, wait for stop
            if (s_reg.sda_s) begin
              s_next.state = D_IDLE;
            end else begin
              s_next.bitcnt = 4'h1;
            end
          end else if (scl_fall && s_reg.bitcnt == 4'h1) begin
            // Acknowledge asks for the next byte
            load_byte = 1'b1;
          end
        end
      endcase
    end

    if (load_byte) begin
      s_next.tx     = rd_byte;
      s_next.sda_oe = ~rd_byte[7];
      s_next.ptr    = s_reg.ptr + 13'h0001;
      s_next.bitcnt = 4'h1;
      s_next.state  = D_SEND;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg       <= '0;
      s_reg.scl_m <= 1'b1;
      s_reg.scl_s <= 1'b1;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_m <= 1'b1;
      s_reg.sda_s <= 1'b1;
      s_reg.sda_d <= 1'b1;
      s_reg.state <= D_IDLE;
      s_reg.role  <= ROLE_DEV;
    end else begin
      s_reg <= s_next;
    end
  end

  // Array contents are not reset; they model nonvolatile storage
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pbuf_we) begin
      pbuf[pbuf_wa] <= pbuf_wd;
    end
  end

  assign link.s_sda_out = 1'b0;
  assign link.s_sda_oe  = s_reg.sda_oe;
  assign busy           = s_reg.busy;

endmodule
`default_nettype wire

/* tb/eeprom_link_properties.sv */
// Purpose: Link and programming checks for the EEPROM pair.
// Assumes: One sys_clk domain; busy is the slave's status.
// Notes:   Watches the shared two-wire link and the slave busy flag only.
`timescale 1ns/1ns
`default_nettype none
module eeprom_link_properties #(
  parameter int PROG_CYCLES = 64
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link and status
  input wire logic scl,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe,
  input wire logic sda_line,
  input wire logic busy
);
  logic [15:0] run_reg;
  logic [3:0]  gap_reg;
  logic        sda_prev_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Gap counts cycles since a stop; saturates so old stops never match
  always_ff @(posedge sys_clk) begin
    sda_prev_reg <= sda_line;
    run_reg <= busy ? run_reg + 16'h0001 : 16'h0000;
    if (!resetn) begin
      gap_reg <= 4'hf;
    end else if (scl && sda_line && !sda_prev_reg) begin
      gap_reg <= 4'h0;
    end else if (gap_reg != 4'hf) begin
      gap_reg <= gap_reg + 4'h1;
    end
  end

  a_busy_quiet_link:
    assert property (busy |-> !s_sda_oe) else $error("slave drove link while busy");
  a_prog_time_bound:
    assert property ($fell(busy) |-> run_reg >= PROG_CYCLES - 1 && run_reg <= PROG_CYCLES + 1)
      else $error("programming length off");
  a_prog_after_stop:
    assert property ($rose(busy) |-> gap_reg < 4'hc) else $error("programming began without stop");
  a_prog_min_hold:
    assert property ($rose(busy) |=> busy [*8]) else $error("programming ended at once");
  a_slave_drive_stable:
    assert property (scl && $past(scl) |-> $stable(s_sda_oe)) else $error("slave moved data in clock high");
  a_ack_held_high:
    assert property ($rose(scl) && s_sda_oe |-> s_sda_oe [*8]) else $error("slave bit dropped early");
  a_scl_high_width:
    assert property ($rose(scl) |-> scl [*8]) else $error("clock high too short");
  a_scl_low_width:
    assert property ($fell(scl) |-> !scl [*8]) else $error("clock low too short");

  cover property ($rose(busy));
  cover property (busy && $rose(scl));
  cover property ($rose(scl) && s_sda_oe);
endmodule
`default_nettype wire

/* tb/serial_eeprom_access_protocol_bench.sv */
// Purpose: Bench joining the EEPROM slave and its bus master.
// Assumes: 10 MHz sys_clk; programming shortened to 600 cycles, so a write after a programmed one must poll.
// Notes:   Reads pile up in the master FIFO, then are drained.
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_access_protocol_bench;
  localparam int PROG = 32'h0000_0258;
  logic        sys_clk;
  logic        resetn;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_read;
  logic [12:0] cmd_addr;
  logic [7:0]  cmd_wdata;
  logic [2:0]  target_select;
  logic [2:0]  device_select_pins;
  logic        write_protect_input;
  logic        rd_valid;
  logic        rd_ready;
  logic [7:0]  rd_data;
  logic        m_busy;
  logic        s_busy;
  logic        nack_error;
  int          error_cnt;
  int          checks;
  int          n;
  logic [12:0] addrs [5] = '{13'h0123, 13'h0124, 13'h1800, 13'h17ff, 13'h1fff};
  logic [7:0]  datas [5] = '{8'h5a, 8'ha5, 8'h11, 8'h33, 8'h77};

  eeprom_link_if eeprom_link_if_i ();
  eeprom_slave #(.PROG_CYCLES(PROG)) eeprom_slave_i (.sys_clk(sys_clk), .resetn(resetn),
    .link(eeprom_link_if_i.slave), .device_select_pins(device_select_pins),
    .write_protect_input(write_protect_input), .busy(s_busy));
  eeprom_master eeprom_master_i (.sys_clk(sys_clk), .resetn(resetn), .link(eeprom_link_if_i.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .target_select(target_select), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .busy(m_busy), .nack_error(nack_error));
  eeprom_link_properties #(.PROG_CYCLES(PROG)) eeprom_link_properties_i (.sys_clk(sys_clk),
    .resetn(resetn), .scl(eeprom_link_if_i.scl), .m_sda_out(eeprom_link_if_i.m_sda_out),
    .m_sda_oe(eeprom_link_if_i.m_sda_oe), .s_sda_out(eeprom_link_if_i.s_sda_out),
    .s_sda_oe(eeprom_link_if_i.s_sda_oe), .sda_line(eeprom_link_if_i.sda_line), .busy(s_busy));

  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ready(input int lim);
    n = 0;
    while (cmd_ready !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic issue(input logic rd, input logic [12:0] addr, input logic [7:0] data);
    wait_ready(20000);
    check("cmd_ready", 13'h0001, {12'h000, cmd_ready});
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = addr;
    cmd_wdata = data;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    check("busy", 13'h0001, {12'h000, m_busy});
  endtask

  // Write returns after stop; a busy slave forces the master to poll
  task automatic write(input logic [12:0] addr, input logic [7:0] data);
    issue(1'b0, addr, data);
    wait_ready(20000);
    check("nack_error", 13'h0000, {12'h000, nack_error});
  endtask

  task automatic take(input logic [7:0] exp);
    n = 0;
    while (rd_valid !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("rd_valid", 13'h0001, {12'h000, rd_valid});
    check("rd_data", {5'h00, exp}, {5'h00, rd_data});
    rd_ready = 1'b1;
    @(posedge sys_clk);
    #1;
    rd_ready = 1'b0;
    // Let an edge pass so a following take never re-raises ready in the same step
    @(posedge sys_clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 13'h0000;
    cmd_wdata = 8'h00;
    target_select = 3'h5;
    device_select_pins = 3'h5;
    write_protect_input = 1'b0;
    rd_ready = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    write(addrs[0], datas[0]);
    check("s_busy", 13'h0001, {12'h000, s_busy});
    write(addrs[1], datas[1]);
    target_select = 3'h2;
    device_select_pins = 3'h2;
    write(addrs[2], datas[2]);
    write_protect_input = 1'b1;
    write(13'h1800, 8'h22);
    check("s_busy", 13'h0000, {12'h000, s_busy});
    write(addrs[3], datas[3]);
    write_protect_input = 1'b0;
    write(addrs[4], datas[4]);
    // Five reads into a four-deep FIFO: the last one must stall
    for (int i = 0; i < 5; i++) begin
      issue(1'b1, addrs[i], 8'h00);
    end
    wait_ready(8000);
    check("cmd_ready", 13'h0000, {12'h000, cmd_ready});
    for (int i = 0; i < 5; i++) begin
      take(datas[i]);
    end
    wait_ready(200);
    check("rd_valid", 13'h0000, {12'h000, rd_valid});
    report_and_stop;
  end
endmodule
`default_nettype wire
